// file: rtl/dpc_consts.svh
// Behaviour
// - Identity register shows revision code high nibble, part code low; writes ignored.
// - Config bit 7 set reduces the bias boost switch current limit.
// - Config bit 6 set reduces the negative converter switch current limit.
// - Short threshold field: 00 off, 01 3V, 10 6V, 11 7.8V.
// - Config bit 3 picks backlight frequency: 0 2.2MHz default, 1 440kHz.
// - Config bit 2 set turns backlight spread spectrum off.
// - Config bit 1 picks bias frequency 2.2MHz or 420kHz; pumps stay 400kHz.
// - Config bit 0 set turns bias spread spectrum off.
// - Config resets to zero except short threshold field, which resets to 3.
// - Enable bit 6 switches the bias boost converter on and off.
// - Enable bit 5 switches positive source on, forcing bias boost on.
// - Enable bit 4 switches negative converter on, forcing bias boost on.
// - Enable bit 3 switches positive gate regulator on, forcing bias boost on.
// - Enable bit 2 switches negative gate regulator on, forcing bias boost on.
// - Enable register resets to all enables off with phase shift bit set.
// - Enable bit 1 starts backlight only after bias soft-start has finished.
// - Phase shift bit is sampled only at backlight start; later changes ignored.
// - Answers address 0x40/0x41 with strap low, 0x48/0x49 with strap high.
// - Chip-activate low for 25us resets interface and all registers.
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

// Register offsets
`define REG_IDENT 8'h00
`define REG_CONFIG 8'h01
`define REG_ENABLES 8'h02
`define REG_PLUS 8'h03
`define REG_GATE_HI 8'h04
`define REG_GATE_LO 8'h05
`define REG_TRIM 8'h06
`define REG_STR_FLT 8'h07
`define REG_SUP_FLT 8'h08
`define REG_DEV_STAT 8'h09
`define REG_STR_MASK 8'h0A
`define REG_SUP_MASK 8'h0B
`define REG_THM_MASK 8'h0C
`define REG_COUNT 8'h0D

// Config fields
`define CFG_BOOST_LIM 7
`define CFG_NEG_LIM 6
`define CFG_SHORT_HI 5
`define CFG_SHORT_LO 4
`define CFG_BL_FREQ 3
`define CFG_BL_SPREAD 2
`define CFG_BIAS_FREQ 1
`define CFG_BIAS_SPREAD 0

// Enable fields
`define EN_BOOST 6
`define EN_POS 5
`define EN_NEG 4
`define EN_GATE_HI 3
`define EN_GATE_LO 2
`define EN_BACKLIGHT 1
`define EN_PHASE 0

// Reset values
`define RST_NONE 8'h00
`define RST_CONFIG 8'h30
`define RST_ENABLES 8'h01
`define RST_PLUS 8'h14
`define RST_GATE_HI 8'h00
`define RST_GATE_LO 8'h00
`define RST_TRIM 8'h00
`define RST_STR_MASK 8'h00
`define RST_SUP_MASK 8'h00
`define RST_THM_MASK 8'h00

// Writable bits
`define WM_NONE 8'h00
`define WM_CONFIG 8'hFF
`define WM_ENABLES 8'h7F
`define WM_PLUS 8'hFF
`define WM_GATE_HI 8'h3F
`define WM_GATE_LO 8'h1F
`define WM_TRIM 8'h7F
`define WM_STR_MASK 8'hFF
`define WM_SUP_MASK 8'hFF
`define WM_THM_MASK 8'h02

// Serial addresses, 7-bit
`define SLAVE_ADDR_LOW 7'h20
`define SLAVE_ADDR_HIGH 7'h24

// Timing
`define SYS_CLK_NS 4
`define EN_LOW_NS 25000
`define SPIKE_NS 50

`endif

// file: rtl/dpc_pkg.sv
package dpc_pkg;

   typedef enum logic [3:0] {
      LINK_IDLE,
      LINK_ADDR,
      LINK_ADDR_ACK,
      LINK_PTR,
      LINK_PTR_ACK,
      LINK_WRITE,
      LINK_WRITE_ACK,
      LINK_READ,
      LINK_READ_ACK
   } link_state_t;

   typedef struct packed {
      logic boost_lim_low;
      logic neg_lim_low;
      logic [1:0] short_detect_level;
      logic backlight_freq_sel;
      logic backlight_spread_off;
      logic bias_freq_sel;
      logic bias_spread_off;
      logic bias_boost_rail_on;
      logic pos_on;
      logic neg_on;
      logic gate_high_on;
      logic gate_low_on;
      logic backlight_on;
      logic phase_shift;
   } rail_ctrl_t;

   typedef struct packed {
      logic [7:0] plus_rail;
      logic [5:0] gate_high;
      logic [4:0] gate_low;
      logic [6:0] string_trim;
      logic [7:0] string_masks;
      logic [7:0] supply_masks;
      logic [7:0] thermal_masks;
   } settings_t;

   typedef struct packed {
      logic [7:0] string_fault;
      logic [7:0] supply_fault;
      logic [7:0] device_status;
   } status_in_t;

endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Pins
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t sync_q;
   sync_state_t sync_d;

   always_comb begin
      sync_d.meta = i_async;
      sync_d.stable = sync_q.meta;
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync_q <= '{meta: RESET_VAL, stable: RESET_VAL};
      end else begin
         sync_q <= sync_d;
      end
   end

   assign o_sync = sync_q.stable;
endmodule

// file: rtl/display_power_config_regs.sv
`timescale 1ns/1ns
`include "dpc_consts.svh"
module display_power_config_regs #(
   // Arbitrary identity values
   parameter logic [3:0] REVISION_CODE = 4'hA,
   parameter logic [3:0] PART_CODE = 4'h3,
   parameter int EN_LOW_CYCLES = (`EN_LOW_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS,
   parameter int SPIKE_CYCLES = (`SPIKE_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Device pins
   input wire logic i_chip_active,
   input wire logic i_addr_sel,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   // Analog side
   input wire logic i_bias_softstart_done,
   input wire dpc_pkg::status_in_t i_status,
   output dpc_pkg::rail_ctrl_t o_ctrl,
   output dpc_pkg::settings_t o_settings
);
   localparam int EN_W = $clog2(EN_LOW_CYCLES + 1);
   localparam int SP_W = $clog2(SPIKE_CYCLES + 1);
   localparam int SYNC_W = 29;

   localparam logic [12:0][7:0] REG_RST = {
      `RST_THM_MASK, `RST_SUP_MASK, `RST_STR_MASK,
      `RST_NONE, `RST_NONE, `RST_NONE,
      `RST_TRIM, `RST_GATE_LO, `RST_GATE_HI, `RST_PLUS,
      `RST_ENABLES, `RST_CONFIG, `RST_NONE
   };
   localparam logic [12:0][7:0] WR_MASK = {
      `WM_THM_MASK, `WM_SUP_MASK, `WM_STR_MASK,
      `WM_NONE, `WM_NONE, `WM_NONE,
      `WM_TRIM, `WM_GATE_LO, `WM_GATE_HI, `WM_PLUS,
      `WM_ENABLES, `WM_CONFIG, `WM_NONE
   };

   typedef struct packed {
      dpc_pkg::link_state_t st;
      logic [2:0] bits;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic rw;
      logic nack;
      logic sda_oe_n;
      logic [1:0] filt;
      logic [1:0][SP_W-1:0] fcnt;
      logic [12:0][7:0] regs;
      logic bl_on;
      logic phase;
      logic [EN_W-1:0] en_cnt;
   } state_t;

   localparam state_t RST_STATE = '{
      st: dpc_pkg::LINK_IDLE,
      bits: '0,
      shift: '0,
      ptr: '0,
      rw: 1'b0,
      nack: 1'b0,
      sda_oe_n: 1'b1,
      filt: 2'h3,
      fcnt: '0,
      regs: REG_RST,
      bl_on: 1'b0,
      phase: 1'b0,
      en_cnt: '0
   };

   state_t state_q;
   state_t state_d;

   // Pin and analog synchronisers
   logic [SYNC_W-1:0] sync_out;
   logic s_en;
   logic s_addr;
   logic s_scl;
   logic s_sda;
   logic s_soft;
   dpc_pkg::status_in_t s_status;

   pin_sync #(
      .WIDTH(SYNC_W),
      .RESET_VAL({5'h1C, 24'h000000})
   ) u_pin_sync (
      .i_sys_clk(i_sys_clk),
      .i_reset_n(i_reset_n),
      .i_async({i_chip_active, i_scl, i_sda, i_addr_sel, i_bias_softstart_done, i_status}),
      .o_sync(sync_out)
   );

   assign {s_en, s_scl, s_sda, s_addr, s_soft, s_status} = sync_out;

   function automatic logic [7:0] read_reg(input logic [7:0] idx, input state_t q,
                                           input dpc_pkg::status_in_t st);
      logic [7:0] val;
      val = 8'h00;
      case (idx)
         `REG_IDENT: val = {REVISION_CODE, PART_CODE};
         `REG_STR_FLT: val = st.string_fault;
         `REG_SUP_FLT: val = st.supply_fault;
         `REG_DEV_STAT: val = st.device_status;
         default: begin
            if (idx < `REG_COUNT) begin
               val = q.regs[idx[3:0]] & WR_MASK[idx[3:0]];
            end
         end
      endcase
      return val;
   endfunction

   logic [1:0] raw;
   logic [1:0] f_next;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic [6:0] my_addr;
   logic [7:0] rd_byte;
   logic [7:0] in_byte;
   logic [3:0] widx;
   logic bl_req;

   always_comb begin
      state_d = state_q;
      raw = {s_scl, s_sda};
      // Spike filter: a line level is taken only after staying put
      for (int i = 0; i < 2; i++) begin
         if (raw[i] == state_q.filt[i]) begin
            state_d.fcnt[i] = '0;
         end else if (state_q.fcnt[i] == SP_W'(SPIKE_CYCLES - 1)) begin
            state_d.fcnt[i] = '0;
            state_d.filt[i] = raw[i];
         end else begin
            state_d.fcnt[i] = state_q.fcnt[i] + SP_W'(1);
         end
      end
      f_next = state_d.filt;
      scl_rise = f_next[1] & ~state_q.filt[1];
      scl_fall = ~f_next[1] & state_q.filt[1];
      start_cond = f_next[1] & state_q.filt[1] & state_q.filt[0] & ~f_next[0];
      stop_cond = f_next[1] & state_q.filt[1] & ~state_q.filt[0] & f_next[0];
      my_addr = s_addr ? `SLAVE_ADDR_HIGH : `SLAVE_ADDR_LOW;
      rd_byte = read_reg(state_q.ptr, state_q, s_status);
      in_byte = {state_q.shift[6:0], f_next[0]};
      widx = state_q.ptr[3:0];

      if (start_cond) begin
         state_d.st = dpc_pkg::LINK_ADDR;
         state_d.bits = '0;
         state_d.sda_oe_n = 1'b1;
      end else if (stop_cond) begin
         state_d.st = dpc_pkg::LINK_IDLE;
         state_d.sda_oe_n = 1'b1;
      end else begin
         unique case (state_q.st)
            dpc_pkg::LINK_IDLE: begin
               state_d.sda_oe_n = 1'b1;
            end
            dpc_pkg::LINK_ADDR: begin
               if (scl_rise) begin
                  state_d.shift = in_byte;
                  state_d.bits = state_q.bits + 3'h1;
                  if (state_q.bits == 3'h7) begin
                     state_d.rw = f_next[0];
                     if (state_q.shift[6:0] == my_addr) begin
                        state_d.st = dpc_pkg::LINK_ADDR_ACK;
                     end else begin
                        state_d.st = dpc_pkg::LINK_IDLE;
                     end
                  end
               end
            end
            dpc_pkg::LINK_PTR, dpc_pkg::LINK_WRITE: begin
               if (scl_rise) begin
                  state_d.shift = in_byte;
                  state_d.bits = state_q.bits + 3'h1;
                  if (state_q.bits == 3'h7) begin
                     if (state_q.st == dpc_pkg::LINK_PTR) begin
                        state_d.ptr = in_byte;
                        state_d.st = dpc_pkg::LINK_PTR_ACK;
                     end else begin
                        // Identity and flag words carry no writable bits
                        if (state_q.ptr < `REG_COUNT) begin
                           state_d.regs[widx] = (state_q.regs[widx] & ~WR_MASK[widx])
                              | (in_byte & WR_MASK[widx]);
                        end
                        state_d.ptr = state_q.ptr + 8'h01;
                        state_d.st = dpc_pkg::LINK_WRITE_ACK;
                     end
                  end
               end
            end
            dpc_pkg::LINK_ADDR_ACK, dpc_pkg::LINK_PTR_ACK, dpc_pkg::LINK_WRITE_ACK: begin
               if (scl_fall) begin
                  if (state_q.sda_oe_n) begin
                     state_d.sda_oe_n = 1'b0;
                  end else begin
                     state_d.bits = '0;
                     state_d.sda_oe_n = 1'b1;
                     if (state_q.st == dpc_pkg::LINK_ADDR_ACK && state_q.rw) begin
                        state_d.st = dpc_pkg::LINK_READ;
                        state_d.shift = rd_byte;
                        state_d.sda_oe_n = rd_byte[7];
                        state_d.ptr = state_q.ptr + 8'h01;
                     end else begin
                        state_d.st = (state_q.st == dpc_pkg::LINK_ADDR_ACK)
                           ? dpc_pkg::LINK_PTR : dpc_pkg::LINK_WRITE;
                     end
                  end
               end
            end
            dpc_pkg::LINK_READ: begin
               if (scl_fall) begin
                  if (state_q.bits == 3'h7) begin
                     state_d.sda_oe_n = 1'b1;
                     state_d.st = dpc_pkg::LINK_READ_ACK;
                  end else begin
                     state_d.bits = state_q.bits + 3'h1;
                     state_d.shift = {state_q.shift[6:0], 1'b0};
                     state_d.sda_oe_n = state_q.shift[6];
                  end
               end
            end
            dpc_pkg::LINK_READ_ACK: begin
               if (scl_rise) begin
                  state_d.nack = f_next[0];
               end
               if (scl_fall) begin
                  if (state_q.nack) begin
                     state_d.st = dpc_pkg::LINK_IDLE;
                  end else begin
                     state_d.st = dpc_pkg::LINK_READ;
                     state_d.bits = '0;
                     state_d.shift = rd_byte;
                     state_d.sda_oe_n = rd_byte[7];
                     state_d.ptr = state_q.ptr + 8'h01;
                  end
               end
            end
         endcase
      end

      // Backlight start and phase sampling
      bl_req = state_q.regs[`REG_ENABLES][`EN_BACKLIGHT] & s_soft;
      state_d.bl_on = bl_req;
      if (bl_req && !state_q.bl_on) begin
         state_d.phase = state_q.regs[`REG_ENABLES][`EN_PHASE];
      end

      // Chip-activate held low clears interface and registers
      if (s_en) begin
         state_d.en_cnt = '0;
      end else if (state_q.en_cnt != EN_W'(EN_LOW_CYCLES)) begin
         state_d.en_cnt = state_q.en_cnt + EN_W'(1);
      end else begin
         state_d = RST_STATE;
         state_d.filt = state_q.filt;
         state_d.en_cnt = state_q.en_cnt;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= RST_STATE;
      end else begin
         state_q <= state_d;
      end
   end

   // Open-drain data line: only ever pulled low
   assign o_sda_out = 1'b0;
   assign o_sda_oe_n = state_q.sda_oe_n;

   logic [7:0] cfg;
   logic [7:0] ens;
   assign cfg = state_q.regs[`REG_CONFIG];
   assign ens = state_q.regs[`REG_ENABLES];

   always_comb begin
      o_ctrl.boost_lim_low = cfg[`CFG_BOOST_LIM];
      o_ctrl.neg_lim_low = cfg[`CFG_NEG_LIM];
      o_ctrl.short_detect_level = cfg[`CFG_SHORT_HI:`CFG_SHORT_LO];
      o_ctrl.backlight_freq_sel = cfg[`CFG_BL_FREQ];
      o_ctrl.backlight_spread_off = cfg[`CFG_BL_SPREAD];
      o_ctrl.bias_freq_sel = cfg[`CFG_BIAS_FREQ];
      o_ctrl.bias_spread_off = cfg[`CFG_BIAS_SPREAD];
      o_ctrl.pos_on = ens[`EN_POS];
      o_ctrl.neg_on = ens[`EN_NEG];
      o_ctrl.gate_high_on = ens[`EN_GATE_HI];
      o_ctrl.gate_low_on = ens[`EN_GATE_LO];
      o_ctrl.bias_boost_rail_on = ens[`EN_BOOST] | ens[`EN_POS] | ens[`EN_NEG]
         | ens[`EN_GATE_HI] | ens[`EN_GATE_LO];
      o_ctrl.backlight_on = state_q.bl_on;
      o_ctrl.phase_shift = state_q.phase;
   end

   always_comb begin
      o_settings.plus_rail = state_q.regs[`REG_PLUS];
      o_settings.gate_high = state_q.regs[`REG_GATE_HI][5:0];
      o_settings.gate_low = state_q.regs[`REG_GATE_LO][4:0];
      o_settings.string_trim = state_q.regs[`REG_TRIM][6:0];
      o_settings.string_masks = state_q.regs[`REG_STR_MASK];
      o_settings.supply_masks = state_q.regs[`REG_SUP_MASK];
      o_settings.thermal_masks = state_q.regs[`REG_THM_MASK];
   end
endmodule

// file: testbench/dpc_regs_checker.sv
`timescale 1ns/1ns
module dpc_regs_checker #(
   parameter int EN_LOW_CYCLES = 6250
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Pins
   input wire logic i_chip_active,
   input wire logic i_scl,
   input wire logic i_bias_softstart_done,
   input wire logic o_sda_out,
   input wire logic o_sda_oe_n,
   // Analog side
   input wire dpc_pkg::rail_ctrl_t o_ctrl,
   input wire dpc_pkg::settings_t o_settings
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_reset_n);

   // Consecutive low samples of chip-activate
   logic [15:0] low_cnt_q;
   logic [15:0] low_cnt_d;
   always_comb begin
      low_cnt_d = low_cnt_q;
      if (i_chip_active)
         low_cnt_d = 16'h0000;
      else if (low_cnt_q != 16'hFFFF)
         low_cnt_d = low_cnt_q + 16'h0001;
   end
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         low_cnt_q <= 16'h0000;
      else
         low_cnt_q <= low_cnt_d;
   end

   sequence s_ss_low;
      !i_bias_softstart_done [*5];
   endsequence
   sequence s_scl_high;
      i_scl [*8];
   endsequence

   property p_rail_or;
      o_ctrl.pos_on || o_ctrl.neg_on || o_ctrl.gate_high_on || o_ctrl.gate_low_on
         |-> o_ctrl.bias_boost_rail_on;
   endproperty
   a_rail_or: assert property (p_rail_or)
      else $error("bias boost off while a rail is on");
   property p_start_gate;
      $rose(o_ctrl.backlight_on) |-> $past(i_bias_softstart_done, 2);
   endproperty
   a_start_gate: assert property (p_start_gate)
      else $error("backlight started before soft-start");
   property p_softstart_gate;
      s_ss_low |-> !o_ctrl.backlight_on;
   endproperty
   a_softstart_gate: assert property (p_softstart_gate)
      else $error("backlight on without soft-start");
   property p_phase_hold;
      o_ctrl.backlight_on && $past(o_ctrl.backlight_on) |-> $stable(o_ctrl.phase_shift);
   endproperty
   a_phase_hold: assert property (p_phase_hold)
      else $error("phase shift changed while backlight running");
   property p_reset_image;
      $rose(i_reset_n) |-> o_ctrl == 15'h1800 && o_settings.plus_rail == 8'h14 && o_sda_oe_n;
   endproperty
   a_reset_image: assert property (p_reset_image)
      else $error("outputs not at reset values");
   property p_open_drain;
      !o_sda_oe_n |-> !o_sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("data line driven high");
   property p_sda_quiet;
      s_scl_high |-> $stable(o_sda_oe_n);
   endproperty
   a_sda_quiet: assert property (p_sda_quiet)
      else $error("data changed while clock high");
   property p_chip_reset;
      low_cnt_q > EN_LOW_CYCLES + 6
         |-> o_ctrl == 15'h1800 && o_settings.plus_rail == 8'h14 && o_sda_oe_n;
   endproperty
   a_chip_reset: assert property (p_chip_reset)
      else $error("long chip-activate low did not reset");
endmodule

bind display_power_config_regs dpc_regs_checker #(.EN_LOW_CYCLES(EN_LOW_CYCLES)) u_chk (
   .i_sys_clk(i_sys_clk),
   .i_reset_n(i_reset_n),
   .i_chip_active(i_chip_active),
   .i_scl(i_scl),
   .i_bias_softstart_done(i_bias_softstart_done),
   .o_sda_out(o_sda_out),
   .o_sda_oe_n(o_sda_oe_n),
   .o_ctrl(o_ctrl),
   .o_settings(o_settings)
);

// file: testbench/i2c_host_model.sv
`timescale 1ns/1ns
module i2c_host_model #(
   parameter int HALF = 20
) (
   // Clock
   input wire logic i_sys_clk,
   // Bus
   input wire logic i_sda_line,
   output logic o_scl,
   output logic o_sda
);
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic w();
      repeat (HALF) @(negedge i_sys_clk);
   endtask
   // Keeps data apart from the clock fall
   task automatic hold();
      repeat (4) @(negedge i_sys_clk);
   endtask
   task automatic start();
      hold();
      o_sda = 1'b1;
      w();
      o_scl = 1'b1;
      w();
      o_sda = 1'b0;
      w();
      o_scl = 1'b0;
   endtask
   task automatic stop();
      hold();
      o_sda = 1'b0;
      w();
      o_scl = 1'b1;
      w();
      o_sda = 1'b1;
      w();
   endtask
   task automatic bit_clk(input logic b, output logic s);
      hold();
      o_sda = b;
      w();
      o_scl = 1'b1;
      w();
      s = i_sda_line;
      o_scl = 1'b0;
   endtask
   // Byte out MSB first, then the acknowledge clock
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack);
      for (int i = 7; i >= 0; i--) bit_clk(tx[i], rx[i]);
      bit_clk(ack_in, ack);
   endtask
endmodule

// file: testbench/display_power_config_regs_tb.sv
`timescale 1ns/1ns
`include "dpc_consts.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module display_power_config_regs_tb;
   localparam int EN_LOW = 20;
   // Arbitrary identity values
   localparam logic [3:0] REV = 4'h6;
   localparam logic [3:0] PART = 4'hC;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic chip_active = 1'b1;
   logic addr_sel = 1'b0;
   logic softstart = 1'b0;
   dpc_pkg::status_in_t status = 24'hC35A0F;
   wire logic scl;
   wire logic sda_m;
   wire logic sda_line;
   logic sda_out;
   logic sda_oe_n;
   dpc_pkg::rail_ctrl_t ctrl;
   dpc_pkg::settings_t settings;
   logic [6:0] dev_addr = 7'h20;
   int n_fail = 0;
   int num_checks = 0;
   logic [7:0] rst [14] = '{{REV, PART}, 8'h30, 8'h01, 8'h14, 8'h00, 8'h00, 8'h00,
                            8'hC3, 8'h5A, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] cfg [3] = '{8'hE5, 8'h1A, 8'h00};
   wire logic [7:0] cfg_view = {ctrl.boost_lim_low, ctrl.neg_lim_low, ctrl.short_detect_level,
      ctrl.backlight_freq_sel, ctrl.backlight_spread_off, ctrl.bias_freq_sel, ctrl.bias_spread_off};

   assign sda_line = sda_m & (sda_oe_n | sda_out);
   always #2 sys_clk = ~sys_clk;

   display_power_config_regs #(.REVISION_CODE(REV), .PART_CODE(PART), .EN_LOW_CYCLES(EN_LOW),
      .SPIKE_CYCLES(2)) DUT (
      .i_sys_clk(sys_clk),
      .i_reset_n(reset_n),
      .i_chip_active(chip_active),
      .i_addr_sel(addr_sel),
      .i_scl(scl),
      .i_sda(sda_line),
      .o_sda_out(sda_out),
      .o_sda_oe_n(sda_oe_n),
      .i_bias_softstart_done(softstart),
      .i_status(status),
      .o_ctrl(ctrl),
      .o_settings(settings)
   );
   i2c_host_model #(.HALF(20)) M (
      .i_sys_clk(sys_clk),
      .i_sda_line(sda_line),
      .o_scl(scl),
      .o_sda(sda_m)
   );

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      logic [7:0] rx;
      logic a;
      M.start();
      M.xfer({dev_addr, 1'b0}, 1'b1, rx, a);
      `CHK(a, 1'b0)
      M.xfer(ptr, 1'b1, rx, a);
      M.xfer(d, 1'b1, rx, a);
      M.stop();
   endtask
   task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
      logic [7:0] rx;
      logic a;
      M.start();
      M.xfer({dev_addr, 1'b0}, 1'b1, rx, a);
      M.xfer(ptr, 1'b1, rx, a);
      M.start();
      M.xfer({dev_addr, 1'b1}, 1'b1, rx, a);
      M.xfer(8'hFF, 1'b1, rx, a);
      M.stop();
      `CHK(rx, e)
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk);
      n_fail++;
      print_verdict();
   end

   initial begin
      logic [7:0] v;
      logic [7:0] rx;
      logic a;
      idle(12);
      reset_n = 1'b1;
      idle(30);
      `CHK(ctrl, 15'h1800)
      for (int i = 0; i < 14; i++) rd(8'(i), rst[i]);
      wr(`REG_IDENT, 8'hFF);
      rd(`REG_IDENT, {REV, PART});
      $display("test reset image done");
      foreach (cfg[i]) begin
         wr(`REG_CONFIG, cfg[i]);
         `CHK(cfg_view, cfg[i])
      end
      $display("test config done");
      for (int b = 2; b < 7; b++) begin
         v = 8'h01 << b;
         wr(`REG_ENABLES, v);
         `CHK(ctrl.bias_boost_rail_on, 1'b1)
         `CHK({ctrl.pos_on, ctrl.neg_on, ctrl.gate_high_on, ctrl.gate_low_on}, v[5:2])
      end
      wr(`REG_ENABLES, 8'h00);
      `CHK(ctrl.bias_boost_rail_on, 1'b0)
      $display("test enables done");
      wr(`REG_ENABLES, 8'h02);
      idle(8);
      `CHK(ctrl.backlight_on, 1'b0)
      softstart = 1'b1;
      idle(8);
      `CHK(ctrl.backlight_on, 1'b1)
      `CHK(ctrl.phase_shift, 1'b0)
      wr(`REG_ENABLES, 8'h03);
      `CHK(ctrl.phase_shift, 1'b0)
      softstart = 1'b0;
      idle(8);
      `CHK(ctrl.backlight_on, 1'b0)
      // Restart takes the phase bit now set
      softstart = 1'b1;
      idle(8);
      `CHK(ctrl.phase_shift, 1'b1)
      softstart = 1'b0;
      idle(8);
      $display("test backlight done");
      wr(`REG_ENABLES, 8'hFF);
      rd(`REG_ENABLES, 8'h7F);
      wr(`REG_GATE_LO, 8'hFF);
      rd(`REG_GATE_LO, 8'h1F);
      // Burst write across the flag words, pointer auto-increments
      M.start();
      M.xfer({dev_addr, 1'b0}, 1'b1, rx, a);
      M.xfer(`REG_GATE_HI, 1'b1, rx, a);
      for (int i = 0; i < 9; i++) M.xfer(8'hFF, 1'b1, rx, a);
      M.stop();
      `CHK(settings, {8'h14, 6'h3F, 5'h1F, 7'h7F, 8'hFF, 8'hFF, 8'h02})
      rd(`REG_THM_MASK, 8'h02);
      // Burst read with a master acknowledge between bytes
      M.start();
      M.xfer({dev_addr, 1'b0}, 1'b1, rx, a);
      M.xfer(`REG_STR_FLT, 1'b1, rx, a);
      M.start();
      M.xfer({dev_addr, 1'b1}, 1'b1, rx, a);
      M.xfer(8'hFF, 1'b0, rx, a);
      `CHK(rx, 8'hC3)
      M.xfer(8'hFF, 1'b1, rx, a);
      M.stop();
      `CHK(rx, 8'h5A)
      $display("test reserved bits done");
      M.start();
      M.xfer({7'h24, 1'b0}, 1'b1, rx, a);
      M.stop();
      `CHK(a, 1'b1)
      addr_sel = 1'b1;
      idle(8);
      dev_addr = 7'h24;
      wr(`REG_PLUS, 8'h5C);
      `CHK(settings.plus_rail, 8'h5C)
      $display("test address done");
      wr(`REG_CONFIG, 8'hC0);
      chip_active = 1'b0;
      idle(EN_LOW - 5);
      chip_active = 1'b1;
      idle(8);
      `CHK(ctrl.boost_lim_low, 1'b1)
      chip_active = 1'b0;
      idle(EN_LOW + 12);
      chip_active = 1'b1;
      idle(30);
      `CHK(ctrl, 15'h1800)
      `CHK(settings.plus_rail, 8'h14)
      `CHK(settings, {8'h14, 42'h0})
      rd(`REG_ENABLES, 8'h01);
      $display("test chip activate done");
      print_verdict();
   end
endmodule
